// >>> rtl/tgc_pkg.sv
// tgc_pkg: register map, field positions and reset values of the timer
// gate control block; assumes a 32-bit AXI4-Lite slave port.
package tgc_pkg;

    // bus geometry
    localparam int unsigned TGC_ADDR_W = 8;
    localparam int unsigned TGC_DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] TGC_OFF_GATE_CTRL  = 8'h00;
    localparam logic [7:0] TGC_OFF_RUN_CTRL   = 8'h04;
    localparam logic [7:0] TGC_OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] TGC_OFF_IRQ_MASK   = 8'h0C;
    localparam logic [7:0] TGC_OFF_STATE      = 8'h10;

    // gate_control field positions
    localparam int unsigned TGC_GE_BIT  = 7;
    localparam int unsigned TGC_POL_BIT = 6;
    localparam int unsigned TGC_TM_BIT  = 5;
    localparam int unsigned TGC_SPM_BIT = 4;
    localparam int unsigned TGC_ACQ_BIT = 3;

    // run control and state fields
    localparam int unsigned TGC_RUN_BIT      = 0;
    localparam int unsigned TGC_ST_GATE_BIT  = 0;
    localparam int unsigned TGC_ST_TFF_BIT   = 1;
    localparam int unsigned TGC_ST_IN_BIT    = 2;

    // interrupt event bits
    localparam int unsigned TGC_IRQ_W        = 2;
    localparam int unsigned TGC_EV_EDGE_BIT  = 0;
    localparam int unsigned TGC_EV_DONE_BIT  = 1;

    // reset values
    localparam logic [TGC_IRQ_W-1:0] TGC_MASK_RST = 2'h0;
    localparam logic                 TGC_CTL_RST  = 1'b0;

    // axi responses
    localparam logic [1:0] TGC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TGC_RESP_SLVERR = 2'h2;

    // single-pulse sequencer
    typedef enum logic [1:0]
    {
        TGC_SP_IDLE  = 2'b00,
        TGC_SP_WAIT  = 2'b01,
        TGC_SP_COUNT = 2'b10
    } tgc_sp_state_t;

endpackage

// >>> rtl/tgc_edge.sv
// tgc_edge: one-flop edge finder for a synchronous level
// assumes the level is already synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module tgc_edge
(
    input  wire logic clock,   // block clock
    input  wire logic srst,    // synchronous reset, high
    input  wire logic level,   // watched level
    output logic      rise,    // level went 0 to 1 this cycle
    output logic      fall     // level went 1 to 0 this cycle
);
    logic prev;       // level one cycle ago
    logic next_prev;  // next value of prev

    // next value is simply the present level
    always_comb
    begin
        next_prev = level;
    end

    // reset low so a high level right after reset counts as a rise
    always_ff @(posedge clock)
    begin
        if (srst)
            prev <= 1'b0;
        else
            prev <= next_prev;
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule
`default_nettype wire

// >>> rtl/tgc_top.sv
// tgc_top: timer gate control with an AXI4-Lite register slave
// assumes gate_in is synchronous to clock; count_gate qualifies
// the counter core outside this block
`timescale 1ns/1ps
`default_nettype none
module tgc_top
    import tgc_pkg::*;
(
    input  wire logic                  clock,    // 100 MHz block clock
    input  wire logic                  srst,     // synchronous reset
    // write address channel
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [TGC_ADDR_W-1:0] awaddr,
    // write data channel
    input  wire logic                  wvalid,
    output logic                       wready,
    input  wire logic [TGC_DATA_W-1:0] wdata,
    input  wire logic [3:0]            wstrb,
    // write response channel
    output logic                       bvalid,
    input  wire logic                  bready,
    output logic [1:0]                 bresp,
    // read address channel
    input  wire logic                  arvalid,
    output logic                       arready,
    input  wire logic [TGC_ADDR_W-1:0] araddr,
    // read data channel
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic [TGC_DATA_W-1:0]      rdata,
    output logic [1:0]                 rresp,
    // gate side
    input  wire logic                  gate_in,    // external gate
    output logic                       count_gate, // counter qualifier
    output logic                       irq         // level interrupt
);

    // ---------------- write channel state ----------------
    logic                  aw_held;       // address taken, not used
    logic                  next_aw_held;
    logic [TGC_ADDR_W-1:0] awaddr_q;      // captured address
    logic [TGC_ADDR_W-1:0] next_awaddr_q;
    logic                  w_held;        // data taken, not used
    logic                  next_w_held;
    logic [TGC_DATA_W-1:0] wdata_q;       // captured data
    logic [TGC_DATA_W-1:0] next_wdata_q;
    logic                  wstrb0_q;      // only lane 0 is used
    logic                  next_wstrb0_q;
    logic                  next_awready;
    logic                  next_wready;
    logic                  next_bvalid;
    logic [1:0]            next_bresp;
    logic                  wr_fire;       // register write this cycle

    // ---------------- read channel state ----------------
    logic                  next_arready;
    logic                  next_rvalid;
    logic [TGC_DATA_W-1:0] next_rdata;
    logic [1:0]            next_rresp;
    logic                  rd_fire;       // read address taken

    // ---------------- control registers ----------------
    logic                  gate_enable_bit;
    logic                  gate_polarity;
    logic                  gate_toggle_mode;
    logic                  gate_single_pulse_mode;
    logic                  timer_run_enable;
    logic [TGC_IRQ_W-1:0]  irq_mask;
    logic                  next_ge;
    logic                  next_pol;
    logic                  next_tm;
    logic                  next_spm;
    logic                  next_run;
    logic [TGC_IRQ_W-1:0]  next_irq_mask;
    logic                  gate_wr;       // write hits gate_control
    logic                  arm_req;       // software arms acquisition

    // ---------------- gate path ----------------
    logic                  toggle_ff;     // gate toggle flip-flop
    logic                  next_toggle_ff;
    tgc_sp_state_t         sp_state;      // single-pulse sequencer
    tgc_sp_state_t         next_sp_state;
    logic                  next_count_gate;
    logic                  active_lvl;    // gate after polarity
    logic                  act_rise;
    logic                  base_lvl;      // after toggle stage
    logic                  base_rise;
    logic                  base_fall;
    logic                  sp_gate;       // single-pulse qualifier
    logic                  gated_lvl;     // final gate function
    logic                  sp_done;       // acquisition finished
    logic                  single_pulse_acquire_status;

    // ---------------- interrupt state ----------------
    logic [TGC_IRQ_W-1:0]  irq_status;
    logic [TGC_IRQ_W-1:0]  next_irq_status;
    logic                  next_irq;
    logic [TGC_IRQ_W-1:0]  events;        // one-cycle event pulses
    logic                  status_rd;     // read of status clears it

    // write channel: address and data accepted in either order,
    // response issued once both are held and no response pending
    always_comb
    begin
        next_aw_held  = aw_held;
        next_awaddr_q = awaddr_q;
        next_w_held   = w_held;
        next_wdata_q  = wdata_q;
        next_wstrb0_q = wstrb0_q;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        wr_fire       = 1'b0;
        if (awvalid && awready)
        begin
            next_aw_held  = 1'b1;
            next_awaddr_q = awaddr;
        end
        if (wvalid && wready)
        begin
            next_w_held   = 1'b1;
            next_wdata_q  = wdata;
            next_wstrb0_q = wstrb[0];
        end
        if (bvalid && bready)
            next_bvalid = 1'b0;
        // a new response waits until the old one is gone
        if (aw_held && w_held && !bvalid)
        begin
            wr_fire     = 1'b1;
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            case (awaddr_q)
                TGC_OFF_GATE_CTRL, TGC_OFF_RUN_CTRL,
                TGC_OFF_IRQ_STATUS, TGC_OFF_IRQ_MASK,
                TGC_OFF_STATE:
                    next_bresp = TGC_RESP_OKAY;
                default:
                    next_bresp = TGC_RESP_SLVERR; // unmapped
            endcase
        end
        next_awready = ~next_aw_held;
        next_wready  = ~next_w_held;
    end

    // write channel registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            aw_held  <= 1'b0;
            awaddr_q <= '0;
            w_held   <= 1'b0;
            wdata_q  <= '0;
            wstrb0_q <= 1'b0;
            awready  <= 1'b1;
            wready   <= 1'b1;
            bvalid   <= 1'b0;
            bresp    <= TGC_RESP_OKAY;
        end
        else
        begin
            aw_held  <= next_aw_held;
            awaddr_q <= next_awaddr_q;
            w_held   <= next_w_held;
            wdata_q  <= next_wdata_q;
            wstrb0_q <= next_wstrb0_q;
            awready  <= next_awready;
            wready   <= next_wready;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
        end
    end

    // read channel: data captured at address handshake, so a
    // status read returns the bits that the same read clears
    always_comb
    begin
        rd_fire      = arvalid && arready;
        next_arready = arready;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (rvalid && rready)
        begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        if (rd_fire)
        begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = '0;
            next_rresp   = TGC_RESP_OKAY;
            case (araddr)
                TGC_OFF_GATE_CTRL:
                begin
                    next_rdata[TGC_GE_BIT]  = gate_enable_bit;
                    next_rdata[TGC_POL_BIT] = gate_polarity;
                    next_rdata[TGC_TM_BIT]  = gate_toggle_mode;
                    next_rdata[TGC_SPM_BIT] = gate_single_pulse_mode;
                    next_rdata[TGC_ACQ_BIT] =
                        single_pulse_acquire_status;
                end
                TGC_OFF_RUN_CTRL:
                    next_rdata[TGC_RUN_BIT] = timer_run_enable;
                TGC_OFF_IRQ_STATUS:
                    next_rdata[TGC_IRQ_W-1:0] = irq_status;
                TGC_OFF_IRQ_MASK:
                    next_rdata[TGC_IRQ_W-1:0] = irq_mask;
                TGC_OFF_STATE:
                begin
                    next_rdata[TGC_ST_GATE_BIT] = count_gate;
                    next_rdata[TGC_ST_TFF_BIT]  = toggle_ff;
                    next_rdata[TGC_ST_IN_BIT]   = gate_in;
                end
                default:
                    next_rresp = TGC_RESP_SLVERR;     // unmapped
            endcase
        end
    end

    // read channel registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= TGC_RESP_OKAY;
        end
        else
        begin
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // control registers; byte lane 0 carries every field
    always_comb
    begin
        next_ge       = gate_enable_bit;
        next_pol      = gate_polarity;
        next_tm       = gate_toggle_mode;
        next_spm      = gate_single_pulse_mode;
        next_run      = timer_run_enable;
        next_irq_mask = irq_mask;
        gate_wr = wr_fire && wstrb0_q && awaddr_q == TGC_OFF_GATE_CTRL;
        // arming only makes sense with single-pulse mode on
        arm_req = gate_wr && wdata_q[TGC_ACQ_BIT]
                  && wdata_q[TGC_SPM_BIT];
        if (gate_wr)
        begin
            next_ge  = wdata_q[TGC_GE_BIT];
            next_pol = wdata_q[TGC_POL_BIT];
            next_tm  = wdata_q[TGC_TM_BIT];
            next_spm = wdata_q[TGC_SPM_BIT];
        end
        if (wr_fire && wstrb0_q && awaddr_q == TGC_OFF_RUN_CTRL)
            next_run = wdata_q[TGC_RUN_BIT];
        if (wr_fire && wstrb0_q && awaddr_q == TGC_OFF_IRQ_MASK)
            next_irq_mask = wdata_q[TGC_IRQ_W-1:0];
    end

    // control register storage
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            gate_enable_bit        <= TGC_CTL_RST;
            gate_polarity          <= TGC_CTL_RST;
            gate_toggle_mode       <= TGC_CTL_RST;
            gate_single_pulse_mode <= TGC_CTL_RST;
            timer_run_enable       <= TGC_CTL_RST;
            irq_mask               <= TGC_MASK_RST;
        end
        else
        begin
            gate_enable_bit        <= next_ge;
            gate_polarity          <= next_pol;
            gate_toggle_mode       <= next_tm;
            gate_single_pulse_mode <= next_spm;
            timer_run_enable       <= next_run;
            irq_mask               <= next_irq_mask;
        end
    end

    // polarity stage: active level is high when gating allows counts
    assign active_lvl = gate_polarity ? gate_in : ~gate_in;

    // edges of the polarity-adjusted gate feed the toggle stage
    tgc_edge u_act_edge
    (
        .clock (clock),
        .srst  (srst),
        .level (active_lvl),
        .rise  (act_rise),
        .fall  ()
    );

    // toggle stage output, then its edges for single-pulse use
    assign base_lvl = gate_toggle_mode ? toggle_ff : active_lvl;

    tgc_edge u_base_edge
    (
        .clock (clock),
        .srst  (srst),
        .level (base_lvl),
        .rise  (base_rise),
        .fall  (base_fall)
    );

    // gate path: toggle flip-flop, single-pulse sequencer, final gate
    always_comb
    begin
        next_toggle_ff = toggle_ff;
        next_sp_state  = sp_state;
        sp_done        = 1'b0;
        if (!gate_toggle_mode)
            next_toggle_ff = 1'b0;
        else if (act_rise)
            next_toggle_ff = ~toggle_ff;
        // the pulse that starts in the arming cycle is not taken:
        // counting needs a fresh rising edge seen from WAIT
        case (sp_state)
            TGC_SP_IDLE:
                if (arm_req)
                    next_sp_state = TGC_SP_WAIT;
            TGC_SP_WAIT:
                if (base_rise)
                    next_sp_state = TGC_SP_COUNT;
            TGC_SP_COUNT:
                if (base_fall)
                begin
                    next_sp_state = TGC_SP_IDLE;
                    sp_done       = 1'b1;
                end
            default:
                next_sp_state = TGC_SP_IDLE;
        endcase
        // leaving single-pulse mode abandons any acquisition
        if (!next_spm)
            next_sp_state = TGC_SP_IDLE;
        sp_gate = (sp_state == TGC_SP_WAIT && base_rise)
                  || (sp_state == TGC_SP_COUNT && base_lvl);
        gated_lvl = gate_single_pulse_mode ? sp_gate
                                           : base_lvl;
        // stopped timer: gate enable has no say at all
        if (!timer_run_enable)
            next_count_gate = 1'b0;
        else if (gate_enable_bit)
            next_count_gate = gated_lvl;
        else
            next_count_gate = 1'b1;
    end

    // gate path registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            toggle_ff  <= 1'b0;
            sp_state   <= TGC_SP_IDLE;
            count_gate <= 1'b0;
        end
        else
        begin
            toggle_ff  <= next_toggle_ff;
            sp_state   <= next_sp_state;
            count_gate <= next_count_gate;
        end
    end

    // status bit reads back as pending while an acquisition is open
    assign single_pulse_acquire_status = sp_state != TGC_SP_IDLE;

    // interrupt: sticky events, read clears, a new event wins
    always_comb
    begin
        events = '0;
        events[TGC_EV_EDGE_BIT] = act_rise;
        events[TGC_EV_DONE_BIT] = sp_done;
        status_rd = rd_fire && araddr == TGC_OFF_IRQ_STATUS;
        next_irq_status = (status_rd ? '0 : irq_status) | events;
        // computed from next values so irq tracks status exactly
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // interrupt registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            irq_status <= '0;
            irq        <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            irq        <= next_irq;
        end
    end

    // ---------------- checks ----------------
    chk_run_off_gate: assert property (
        @(posedge clock) disable iff (srst)
        !timer_run_enable |=> !count_gate)
        else $error("gate open while timer stopped");

    chk_free_count: assert property (
        @(posedge clock) disable iff (srst)
        timer_run_enable && !gate_enable_bit |=> count_gate)
        else $error("ungated running timer not counting");

    chk_polarity_gate: assert property (
        @(posedge clock) disable iff (srst)
        timer_run_enable && gate_enable_bit && !gate_toggle_mode
        && !gate_single_pulse_mode
        |=> count_gate == ($past(gate_polarity) ~^ $past(gate_in)))
        else $error("gate level does not follow polarity");

    chk_toggle_flip: assert property (
        @(posedge clock) disable iff (srst)
        gate_toggle_mode && act_rise
        |=> toggle_ff != $past(toggle_ff))
        else $error("toggle flip-flop missed an edge");

    chk_toggle_clear: assert property (
        @(posedge clock) disable iff (srst)
        !gate_toggle_mode |=> !toggle_ff)
        else $error("toggle flip-flop not cleared");

    chk_pulse_idle: assert property (
        @(posedge clock) disable iff (srst)
        timer_run_enable && gate_enable_bit
        && gate_single_pulse_mode && sp_state == TGC_SP_IDLE
        |=> !count_gate)
        else $error("idle single-pulse logic let gate open");

    chk_status_read: assert property (
        @(posedge clock) disable iff (srst)
        rd_fire && araddr == TGC_OFF_GATE_CTRL
        |=> rdata[TGC_ACQ_BIT] == $past(single_pulse_acquire_status))
        else $error("status bit misreported");

    chk_pulse_end: assert property (
        @(posedge clock) disable iff (srst)
        sp_state == TGC_SP_COUNT && base_fall
        && gate_single_pulse_mode && !arm_req
        |=> !single_pulse_acquire_status
            && irq_status[TGC_EV_DONE_BIT])
        else $error("acquisition not closed at pulse end");

endmodule
`default_nettype wire

// >>> tb/tgc_gate_src.sv
// tgc_gate_src: model of the external gate source feeding gate_in
// assumes the bench asks for a level; the wire follows one edge later
`timescale 1ns/1ps
`default_nettype none
module tgc_gate_src
(
    input  wire logic clock,     // block clock
    input  wire logic srst,      // synchronous reset, high
    input  wire logic level_req, // level asked for by the bench
    output logic      gate_in    // gate wire seen by the block
);
    // registered so the gate moves just after an edge, never on it
    always_ff @(posedge clock)
    begin
        gate_in <= srst ? 1'b0 : level_req;
    end
endmodule
`default_nettype wire

// >>> tb/tb_tgc_top.sv
// tb_tgc_top: self-checking bench for the timer gate control block
// assumes the register map and latencies of the tgc_pkg constants
`timescale 1ns/1ps
`default_nettype none
module tb_tgc_top
    import tgc_pkg::*;
;
    logic       clock, srst, awvalid, awready, wvalid, wready;
    logic       bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic       gate_in, count_gate, irq, gate_req;
    int         errors, check_count;

    tgc_top tgc_top_inst (.clock, .srst, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .gate_in, .count_gate, .irq);
    tgc_gate_src tgc_gate_src_inst (.clock, .srst,
        .level_req(gate_req), .gate_in);

    // one compare, counted; unknowns never match
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1;
        wdata <= v; wstrb <= 4'hF; bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    // read: rready held until rvalid seen; data taken at that edge
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // move the gate, then leave room for source and block latency
    task automatic gate(input logic v);
        @(posedge clock);
        gate_req <= v;
        repeat (4) @(posedge clock);
    endtask

    // single place where the run ends
    task automatic final_report;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // free-running 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // hang guard: the tests need well under 2000 cycles
    initial
    begin
        #100000;
        errors++;
        final_report;
    end

    initial
    begin
        srst = 1'b1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
        rready = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
        gate_req = 0; errors = 0; check_count = 0;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        rd(TGC_OFF_GATE_CTRL); chk(d, 32'h0);
        rd(TGC_OFF_IRQ_MASK); chk(d, 32'h0);
        rd(8'hFC); chk(d, 32'h0);
        chk(r, TGC_RESP_SLVERR);
        wr(8'hFC, 32'hFF); chk(r, TGC_RESP_SLVERR);
        // stopped timer: gate enable and a high gate must not count
        wr(TGC_OFF_GATE_CTRL, 32'hC0);
        gate(1'b1); chk(count_gate, 1'b0);
        wr(TGC_OFF_RUN_CTRL, 32'h1);
        gate(1'b1); chk(count_gate, 1'b1);
        gate(1'b0); chk(count_gate, 1'b0);
        wr(TGC_OFF_GATE_CTRL, 32'h40);
        gate(1'b0); chk(count_gate, 1'b1);
        // active-low gating
        wr(TGC_OFF_GATE_CTRL, 32'h80);
        gate(1'b0); chk(count_gate, 1'b1);
        gate(1'b1); chk(count_gate, 1'b0);
        gate(1'b0);
        // toggle mode: each rising edge flips the qualifier
        wr(TGC_OFF_GATE_CTRL, 32'hE0);
        // count_gate lags the control write by one edge
        @(posedge clock);
        chk(count_gate, 1'b0);
        gate(1'b1); gate(1'b0); chk(count_gate, 1'b1);
        rd(TGC_OFF_STATE); chk(d & 32'h2, 32'h2);
        gate(1'b1); gate(1'b0); chk(count_gate, 1'b0);
        gate(1'b1); gate(1'b0);
        wr(TGC_OFF_GATE_CTRL, 32'hC0);
        rd(TGC_OFF_STATE); chk(d & 32'h2, 32'h0);
        chk(irq, 1'b0);
        // single pulse: arm, count one pulse, hardware clears status
        // toggle phase left active gate edges, no pulse done yet
        rd(TGC_OFF_IRQ_STATUS); chk(d, 32'h1);
        wr(TGC_OFF_IRQ_MASK, 32'h2);
        wr(TGC_OFF_GATE_CTRL, 32'hD8);
        rd(TGC_OFF_GATE_CTRL); chk(d, 32'hD8);
        chk(count_gate, 1'b0);
        gate(1'b1); chk(count_gate, 1'b1);
        gate(1'b0); chk(count_gate, 1'b0);
        rd(TGC_OFF_GATE_CTRL); chk(d, 32'hD0);
        chk(irq, 1'b1);
        rd(TGC_OFF_IRQ_STATUS); chk(d & 32'h2, 32'h2);
        repeat (2) @(posedge clock);
        chk(irq, 1'b0);
        gate(1'b1); chk(count_gate, 1'b0);
        gate(1'b0);
        final_report;
    end
endmodule
`default_nettype wire
